// ===== otc_pkg.sv
// shared constants for the oscillator tuning control block
package otc_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;

  // register addresses
  localparam logic [12:0] ADDR_CONTROL     = 13'h11D;
  localparam logic [12:0] ADDR_TUNING_B0   = 13'h11E;
  localparam logic [12:0] ADDR_TUNING_B1   = 13'h11F;
  localparam logic [12:0] ADDR_TUNING_B2   = 13'h120;
  localparam logic [12:0] ADDR_TUNING_B3   = 13'h121;
  localparam logic [12:0] ADDR_START_PH_LO = 13'h122;
  localparam logic [12:0] ADDR_START_PH_HI = 13'h123;

  // control field positions
  localparam int unsigned CTRL_ENABLE_BIT    = 0;
  localparam int unsigned CTRL_AMP_DITH_BIT  = 1;
  localparam int unsigned CTRL_PH_DITH_BIT   = 2;
  localparam int unsigned CTRL_W             = 3;

  // reset values
  localparam logic [2:0]  CONTROL_RST   = 3'h0;
  localparam logic [31:0] TUNING_RST    = 32'h0000_0000;
  localparam logic [15:0] START_PH_RST  = 16'h0000;
  localparam logic [15:0] LFSR_SEED     = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS     = 16'hB400;

  // datapath widths
  localparam int unsigned SAMPLE_W  = 12;
  localparam int unsigned WAVE_W    = 13;
  localparam int unsigned PROD_W    = 25;
  localparam int unsigned PHASE_W   = 32;
  localparam int unsigned LUTPH_W   = 16;

  // product rounding addend used for amplitude dither, half an output lsb
  localparam logic signed [24:0] AMP_DITH_ADD = 25'sh0000400;

  // quarter-wave magnitude table, full scale 2047
  localparam logic [11:0] QTR_0 = 12'h0C9;
  localparam logic [11:0] QTR_1 = 12'h252;
  localparam logic [11:0] QTR_2 = 12'h3C5;
  localparam logic [11:0] QTR_3 = 12'h513;
  localparam logic [11:0] QTR_4 = 12'h62E;
  localparam logic [11:0] QTR_5 = 12'h70D;
  localparam logic [11:0] QTR_6 = 12'h7A7;
  localparam logic [11:0] QTR_7 = 12'h7F5;

  // quarter-turn offset for the cosine phase
  localparam logic [15:0] QUARTER_TURN = 16'h4000;

endpackage : otc_pkg

// ===== otc_tuning_oscillator.sv
// tuning oscillator: control registers, phase accumulator and mixer
// Contract
// RQ1 - control bit 2 set enables phase dither; cleared runs without it
// RQ2 - control bit 1 set enables amplitude dither; cleared runs without it
// RQ3 - control bit 0 set runs the 32-bit oscillator at the tuning word
// RQ4 - control bit 0 clear bypasses data unchanged and stops the oscillator
// RQ5 - tuning word built from bytes 0x11E (bits 7:0) up to 0x121 (31:24)
// RQ6 - tuning word is twos complement, 2^32 times frequency over sample rate
// RQ7 - start-phase word: 0x122 gives bits 7:0, 0x123 gives bits 15:8
// RQ8 - start-phase word loads on oscillator start and on each sync pulse; a sync while stopped is dropped
// RQ9 - software computes start phase as 2^16 times degrees over 360
// RQ10 - accumulator adds tuning word once per sample, wraps modulo 2^32
`timescale 1ns/10ps
`default_nettype none

module otc_tuning_oscillator
  import otc_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  // register port from the serial port decoder
  input  wire logic                reg_wr_en_in,
  input  wire logic                reg_rd_en_in,
  input  wire logic [ADDR_W-1:0]   reg_addr_in,
  input  wire logic [DATA_W-1:0]   reg_wdata_in,
  output logic      [DATA_W-1:0]   reg_rdata_out,
  output logic                     reg_rvalid_out,
  // sample stream, one enable per divided sample clock
  input  wire logic                sample_en_in,
  input  wire logic [SAMPLE_W-1:0] sample_data_in,
  // external synchronisation pin
  input  wire logic                sync_in,
  // mixed output
  output logic      [SAMPLE_W-1:0] mix_i_out,
  output logic      [SAMPLE_W-1:0] mix_q_out,
  output logic                     mix_valid_out
);

  // signed wave value from a 16-bit phase, quarter table mirrored
  function automatic logic signed [WAVE_W-1:0] wave_of(input logic [LUTPH_W-1:0] ph);
    logic [2:0]  idx;
    logic [11:0] mag;
    idx = ph[14] ? ~ph[13:11] : ph[13:11];
    unique case (idx)
      3'h0: mag = QTR_0;
      3'h1: mag = QTR_1;
      3'h2: mag = QTR_2;
      3'h3: mag = QTR_3;
      3'h4: mag = QTR_4;
      3'h5: mag = QTR_5;
      3'h6: mag = QTR_6;
      3'h7: mag = QTR_7;
    endcase
    return ph[15] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  // ---------------- register file ----------------
  logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
  logic [31:0]        tune_q, tune_d;
  logic [15:0]        sphase_q, sphase_d;
  logic [DATA_W-1:0]  rdata_q, rdata_d;
  logic               rvalid_q, rvalid_d;

  always_comb begin
    ctrl_d   = ctrl_q;
    tune_d   = tune_q;
    sphase_d = sphase_q;
    rvalid_d = reg_rd_en_in;
    rdata_d  = 8'h00;
    if (reg_wr_en_in) begin
      unique case (reg_addr_in)
        ADDR_CONTROL:     ctrl_d          = reg_wdata_in[CTRL_W-1:0];
        ADDR_TUNING_B0:   tune_d[7:0]     = reg_wdata_in; // RQ5
        ADDR_TUNING_B1:   tune_d[15:8]    = reg_wdata_in; // RQ5
        ADDR_TUNING_B2:   tune_d[23:16]   = reg_wdata_in; // RQ5
        ADDR_TUNING_B3:   tune_d[31:24]   = reg_wdata_in; // RQ5
        ADDR_START_PH_LO: sphase_d[7:0]   = reg_wdata_in; // RQ7
        ADDR_START_PH_HI: sphase_d[15:8]  = reg_wdata_in; // RQ7
        default:          ;
      endcase
    end
    // unmapped addresses and reserved bits read as zero
    if (reg_rd_en_in) begin
      unique case (reg_addr_in)
        ADDR_CONTROL:     rdata_d = {5'h00, ctrl_q};
        ADDR_TUNING_B0:   rdata_d = tune_q[7:0];
        ADDR_TUNING_B1:   rdata_d = tune_q[15:8];
        ADDR_TUNING_B2:   rdata_d = tune_q[23:16];
        ADDR_TUNING_B3:   rdata_d = tune_q[31:24];
        ADDR_START_PH_LO: rdata_d = sphase_q[7:0];
        ADDR_START_PH_HI: rdata_d = sphase_q[15:8];
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_q   <= CONTROL_RST;
      tune_q   <= TUNING_RST;
      sphase_q <= START_PH_RST;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      tune_q   <= tune_d;
      sphase_q <= sphase_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // ---------------- sync pin and start detect ----------------
  logic sync_meta_q, sync_meta_d;
  logic sync_sync_q, sync_sync_d;
  logic sync_prev_q, sync_prev_d;
  logic en_prev_q,   en_prev_d;
  logic osc_en;
  logic start_evt;
  logic sync_evt;
  logic load_phase;

  always_comb begin
    sync_meta_d = sync_in;
    sync_sync_d = sync_meta_q;
    sync_prev_d = sync_sync_q;
    en_prev_d   = ctrl_q[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync_meta_q <= 1'b0;
      sync_sync_q <= 1'b0;
      sync_prev_q <= 1'b0;
      en_prev_q   <= 1'b0;
    end else begin
      sync_meta_q <= sync_meta_d;
      sync_sync_q <= sync_sync_d;
      sync_prev_q <= sync_prev_d;
      en_prev_q   <= en_prev_d;
    end
  end

  assign osc_en    = ctrl_q[CTRL_ENABLE_BIT];
  assign start_evt = osc_en & ~en_prev_q;
  // a sync while stopped is dropped: the next start reloads the phase anyway
  assign sync_evt   = osc_en & sync_sync_q & ~sync_prev_q;
  assign load_phase = start_evt | sync_evt; // RQ8

  // ---------------- accumulator, dither and mixer ----------------
  logic [PHASE_W-1:0]       phase_q, phase_d;
  logic [15:0]              lfsr_q, lfsr_d;
  logic [SAMPLE_W-1:0]      mi_q, mi_d;
  logic [SAMPLE_W-1:0]      mq_q, mq_d;
  logic                     mv_q, mv_d;
  logic [LUTPH_W-1:0]       lut_phase;
  logic signed [PROD_W-1:0] amp_add;
  logic signed [PROD_W-1:0] prod_i;
  logic signed [PROD_W-1:0] prod_q;

  always_comb begin
    lut_phase = phase_q[31:16];
    if (ctrl_q[CTRL_PH_DITH_BIT]) begin
      lut_phase = phase_q[31:16] + {12'h000, lfsr_q[3:0]}; // RQ1
    end
    amp_add = '0;
    if (ctrl_q[CTRL_AMP_DITH_BIT] && lfsr_q[0]) begin
      amp_add = AMP_DITH_ADD; // RQ2
    end
    prod_i = $signed(sample_data_in) * wave_of(lut_phase + QUARTER_TURN) + amp_add;
    prod_q = $signed(sample_data_in) * wave_of(lut_phase) + amp_add;

    phase_d = phase_q;
    lfsr_d  = lfsr_q;
    if (load_phase) begin
      phase_d = {sphase_q, 16'h0000}; // RQ8
    end else if (osc_en && sample_en_in) begin
      // twos complement word: negative words simply wrap backwards
      phase_d = phase_q + tune_q; // RQ3 RQ6 RQ10
    end
    // dither source only runs with the oscillator, saving power when stopped
    if (osc_en && sample_en_in) begin
      lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS) : (lfsr_q >> 1);
    end

    mi_d = mi_q;
    mq_d = mq_q;
    mv_d = sample_en_in;
    if (sample_en_in) begin
      if (osc_en) begin
        mi_d = prod_i[22:11]; // RQ3
        mq_d = prod_q[22:11];
      end else begin
        mi_d = sample_data_in; // RQ4
        mq_d = 12'h000;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      phase_q <= 32'h0000_0000;
      lfsr_q  <= LFSR_SEED;
      mi_q    <= 12'h000;
      mq_q    <= 12'h000;
      mv_q    <= 1'b0;
    end else begin
      phase_q <= phase_d;
      lfsr_q  <= lfsr_d;
      mi_q    <= mi_d;
      mq_q    <= mq_d;
      mv_q    <= mv_d;
    end
  end

  assign mix_i_out     = mi_q;
  assign mix_q_out     = mq_q;
  assign mix_valid_out = mv_q;

  // ---------------- checks ----------------
  // reference products without amplitude dither (ref_i also without phase dither), so a stuck dither path shows up
  logic signed [PROD_W-1:0]   ref_i;
  logic signed [PROD_W-1:0]   ref_q;
  logic        [SAMPLE_W-1:0] ref_i_hi;
  logic        [SAMPLE_W-1:0] ref_q_hi;
  assign ref_i    = $signed(sample_data_in) * wave_of(phase_q[31:16] + QUARTER_TURN);
  assign ref_q    = $signed(sample_data_in) * wave_of(lut_phase);
  assign ref_i_hi = ref_i[22:11];
  assign ref_q_hi = ref_q[22:11];

  a_phase_dither_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ1
    (sample_en_in && osc_en && ctrl_q[2:1] == 2'b00)
      |=> mix_i_out == $past(ref_i_hi))
    else $error("undithered mix differs from plain phase");

  a_amp_dither_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ2
    (sample_en_in && osc_en && !ctrl_q[CTRL_AMP_DITH_BIT])
      |=> mix_q_out == $past(ref_q_hi))
    else $error("amplitude dither active while disabled");

  a_phase_advance: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ3
    (osc_en && sample_en_in && !load_phase)
      |=> phase_q == $past(phase_q) + $past(tune_q))
    else $error("accumulator did not advance by tuning word");

  a_bypass_data: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ4
    (!osc_en && sample_en_in)
      |=> mix_valid_out && mix_i_out == $past(sample_data_in) && mix_q_out == 12'h000)
    else $error("bypass did not pass data unchanged");

  a_stopped_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ4
    (!osc_en && !$rose(osc_en)) |=> $stable(phase_q) && $stable(lfsr_q))
    else $error("oscillator ran while disabled");

  a_tuning_bytes: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ5
    (reg_wr_en_in && reg_addr_in == ADDR_TUNING_B3)
      ##1 (reg_rd_en_in && reg_addr_in == ADDR_TUNING_B3)
      |=> reg_rvalid_out && reg_rdata_out == $past(tune_q[31:24]) &&
          tune_q[31:24] == $past(reg_wdata_in, 2))
    else $error("tuning top byte not stored or read back");

  a_negative_word: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ6
    (osc_en && sample_en_in && !load_phase && tune_q[31])
      |=> phase_q == $past(phase_q) - (~$past(tune_q) + 32'h0000_0001))
    else $error("negative tuning word not applied as decrement");

  a_start_phase_hi: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ7
    (reg_wr_en_in && reg_addr_in == ADDR_START_PH_HI)
      |=> sphase_q[15:8] == $past(reg_wdata_in) && $stable(sphase_q[7:0]))
    else $error("start phase high byte not stored");

  a_start_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ8
    $rose(osc_en) |=> phase_q == {$past(sphase_q), 16'h0000})
    else $error("start phase not loaded on start");

  a_sync_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ8
    (osc_en && $rose(sync_sync_q) && $past(sync_prev_q) == $past(sync_sync_q))
      |=> phase_q == {$past(sphase_q), 16'h0000})
    else $error("start phase not loaded on sync");

  a_one_step: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ10
    (!sample_en_in && !load_phase) |=> $stable(phase_q))
    else $error("accumulator moved without a sample enable");

  a_start_phase_lo: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ7
    (reg_wr_en_in && reg_addr_in == ADDR_START_PH_LO)
      |=> sphase_q[7:0] == $past(reg_wdata_in) && $stable(sphase_q[15:8]))
    else $error("start phase low byte not stored");

  a_tuning_low: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ5
    (reg_wr_en_in && reg_addr_in == ADDR_TUNING_B0)
      |=> tune_q[7:0] == $past(reg_wdata_in) && $stable(tune_q[31:8]))
    else $error("tuning low byte not stored");

  a_read_answer: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ5
    reg_rd_en_in |=> reg_rvalid_out)
    else $error("read strobe got no valid answer");

  a_read_idle: assert property (@(posedge core_clk_in) disable iff (rst_in) // RQ7
    !reg_rd_en_in |=> !reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("read data or valid stood without a read");

endmodule : otc_tuning_oscillator

`default_nettype wire

// ===== otc_tuning_oscillator_tb.sv
// self-checking bench for the oscillator tuning control block
`timescale 1ns/10ps
`default_nettype none

module otc_tuning_oscillator_tb
  import otc_pkg::*;
;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic                sen = 1'b0;
  logic                sync = 1'b0;
  logic [ADDR_W-1:0]   addr = '0;
  logic [DATA_W-1:0]   wd = '0;
  logic [SAMPLE_W-1:0] sd = '0;
  logic [DATA_W-1:0]   rdat;
  logic                rval;
  logic [SAMPLE_W-1:0] mi;
  logic [SAMPLE_W-1:0] mq;
  logic                mval;
  logic [31:0]         r = 32'h0C4A;
  logic [31:0]         tw;
  logic [15:0]         st;
  logic [15:0]         p;
  int                  n_mismatch = 0;
  int                  n_compared = 0;

  always #2 clk = ~clk;

  otc_tuning_oscillator u_dut (
    .core_clk_in    (clk),
    .rst_in         (rst),
    .reg_wr_en_in   (wr),
    .reg_rd_en_in   (rd),
    .reg_addr_in    (addr),
    .reg_wdata_in   (wd),
    .reg_rdata_out  (rdat),
    .reg_rvalid_out (rval),
    .sample_en_in   (sen),
    .sample_data_in (sd),
    .sync_in        (sync),
    .mix_i_out      (mi),
    .mix_q_out      (mq),
    .mix_valid_out  (mval)
  );

  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // quarter-wave lookup mirrored and signed per quadrant
  function automatic logic signed [12:0] wave(input logic [15:0] ph);
    logic [2:0]  i;
    logic [11:0] m;
    i = ph[14] ? ~ph[13:11] : ph[13:11];
    case (i)
      3'd0: m = QTR_0;
      3'd1: m = QTR_1;
      3'd2: m = QTR_2;
      3'd3: m = QTR_3;
      3'd4: m = QTR_4;
      3'd5: m = QTR_5;
      3'd6: m = QTR_6;
      default: m = QTR_7;
    endcase
    return ph[15] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  function automatic logic [11:0] mix(input logic [11:0] d, input logic [15:0] ph);
    logic signed [24:0] pr;
    pr = $signed(d) * wave(ph);
    return pr[22:11];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wreg(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wd = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask

  task automatic rreg(input logic [12:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(rval, 1);
    chk(rdat, e);
  endtask

  // dithered outputs may sit one lsb above the plain result
  task automatic smp(input logic [11:0] d, input logic [15:0] ph, input bit byp, input bit dth);
    @(posedge clk);
    #1 sen = 1'b1;
    sd = d;
    @(posedge clk);
    #1 sen = 1'b0;
    chk(mval, 1);
    if (byp) begin
      chk(mi, d);
      chk(mq, 0);
    end else if (!dth) begin
      chk(mi, mix(d, ph + QUARTER_TURN));
      chk(mq, mix(d, ph));
    end else begin
      chk(12'(mi - mix(d, ph + QUARTER_TURN)) <= 12'h001, 1);
      chk(12'(mq - mix(d, ph)) <= 12'h001, 1);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    for (int a = 'h11D; a <= 'h124; a++) rreg(13'(a), 8'h00);
    wreg(ADDR_CONTROL, 8'hFF);
    rreg(ADDR_CONTROL, 8'h07);
    wreg(ADDR_CONTROL, 8'h00);
    wreg(13'h124, 8'h5A);
    rreg(13'h124, 8'h00);
    // write then read the top tuning byte on consecutive edges
    r = nx(r);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = ADDR_TUNING_B3;
    wd = r[7:0];
    @(posedge clk);
    #1 wr = 1'b0;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(rval, 1);
    chk(rdat, r[7:0]);
    for (int i = 0; i < 4; i++) begin
      r = nx(r);
      smp(r[11:0], 16'h0000, 1'b1, 1'b0);
    end
    // negative word in pass one checks twos complement stepping
    for (int k = 0; k < 3; k++) begin
      tw = (k == 1) ? 32'hC000_0000 : 32'h4000_0000;
      r = nx(r);
      // start phase from a random quarter turn given in degrees
      st = 16'((int'(r[1:0]) * 90 * 65536) / 360);
      for (int b = 0; b < 4; b++) wreg(ADDR_TUNING_B0 + 13'(b), tw[8*b+:8]);
      wreg(ADDR_START_PH_LO, st[7:0]);
      wreg(ADDR_START_PH_HI, st[15:8]);
      for (int b = 0; b < 4; b++) rreg(ADDR_TUNING_B0 + 13'(b), tw[8*b+:8]);
      rreg(ADDR_START_PH_LO, st[7:0]);
      rreg(ADDR_START_PH_HI, st[15:8]);
      wreg(ADDR_CONTROL, 8'h00);
      wreg(ADDR_CONTROL, (k == 2) ? 8'h07 : 8'h01);
      p = st;
      for (int i = 0; i < 6; i++) begin
        r = nx(r);
        smp(r[11:0], p, 1'b0, k == 2);
        p = p + tw[31:16];
      end
      @(posedge clk);
      #1 sync = 1'b1;
      repeat (2) @(posedge clk);
      #1 sync = 1'b0;
      repeat (4) @(posedge clk);
      p = st;
      for (int i = 0; i < 3; i++) begin
        r = nx(r);
        smp(r[11:0], p, 1'b0, k == 2);
        p = p + tw[31:16];
      end
    end
    close_out();
  end

endmodule // otc_tuning_oscillator_tb

`default_nettype wire
